// file: rtl/rmlc_consts.svh
// Constants for the upper register map with write lock and checksum.
`ifndef RMLC_CONSTS_SVH
`define RMLC_CONSTS_SVH

// Register addresses, four bits each.
`define RMLC_ADDR_TRIM_B 4'hB
`define RMLC_ADDR_TRIM_C 4'hC
`define RMLC_ADDR_KEY 4'hD
`define RMLC_ADDR_VARIANT 4'hE
`define RMLC_ADDR_CHECKSUM 4'hF

// Reset values.
`define RMLC_RST_TRIM_B 24'h900000
`define RMLC_RST_TRIM_C 8'h30
`define RMLC_RST_KEY 8'hA5
`define RMLC_RST_CHECKSUM 16'h0000

// Key value that opens the trim and variant registers for writing.
`define RMLC_UNLOCK_KEY 8'hA5

// Device address that the top two command bits must carry.
`define RMLC_DEV_ADDR 2'h1

// Checksum generator polynomial and start value.
`define RMLC_CRC_POLY 16'h8005
`define RMLC_CRC_INIT 16'h0000

// Configuration bytes covered by one checksum round, last index.
`define RMLC_CRC_LAST_IDX 3'h6

`endif

// file: rtl/rmlc_crc_step.sv
// One byte step of the configuration checksum, MSB first.
`timescale 1ns/1ps
`include "rmlc_consts.svh"

module rmlc_crc_step (
  // Running checksum in.
  input wire logic [15:0] crc_i,
  // Byte to fold in.
  input wire logic [7:0] data_i,
  // Checksum after the byte.
  output logic [15:0] crc_o
);

  // Shift the byte in bit by bit, feeding back the polynomial.
  always_comb begin
    logic [15:0] acc;
    logic fb;
    acc = crc_i;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = acc[15] ^ data_i[i];
      acc = {acc[14:0], 1'b0};
      if (fb) begin
        acc = acc ^ `RMLC_CRC_POLY;
      end
    end
    crc_o = acc;
  end

endmodule

// file: rtl/rmlc_pkg.sv
// Types shared by the register map lock and checksum block.
package rmlc_pkg;

  // One register command, as decoded from the serial front end.
  typedef struct packed {
    logic [1:0] dev;
    logic [3:0] reg_addr;
    logic write;
    logic [23:0] wdata;
  } rmlc_cmd_s;

  // States of the checksum engine, one-hot.
  typedef enum logic [1:0] {
    RMLC_CRC_IDLE = 2'h1,
    RMLC_CRC_RUN = 2'h2
  } rmlc_crc_e;

endpackage

// file: rtl/rmlc_top.sv
// Upper register map with write lock key and configuration checksum.
`timescale 1ns/1ps
`include "rmlc_consts.svh"

module rmlc_top #(
  // Product variant default; the value is arbitrary.
  parameter logic [15:0] PRODUCT_VARIANT = 16'h0000
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Digital master clock running, one enable per checksum step.
  input wire logic digital_master_clock_i,
  // Register command from the serial front end.
  input wire logic cmd_valid_i,
  input wire rmlc_pkg::rmlc_cmd_s cmd_i,
  // Read answer.
  output logic rd_valid_o,
  output logic [23:0] rd_data_o,
  // Status.
  output logic locked_o,
  output logic wr_blocked_o,
  output logic crc_valid_o
);

  // Register storage.
  logic [23:0] trim_word_b; // Fixed trim word.
  logic [7:0] trim_byte_c; // Fixed trim byte.
  logic [7:0] write_protect_key; // Lock key.
  logic [15:0] product_variant_word; // Product dependent word.
  logic [15:0] config_checksum_value; // Published checksum.

  // Checksum engine state.
  rmlc_pkg::rmlc_crc_e crc_state; // Engine state.
  logic [2:0] byte_idx; // Byte being folded in.
  logic [15:0] crc_acc; // Running checksum.
  logic [7:0] crc_byte; // Selected configuration byte.
  logic [15:0] next_crc; // Checksum after this byte.

  // Decode of the incoming command.
  logic cmd_take; // Command addressed to this device.
  logic cmd_wr; // Write command addressed to this device.
  logic map_locked; // Map is locked by the key.
  logic wr_allow; // Write may change a register.
  logic key_wr; // Write to the key register.
  logic [23:0] next_rd_data; // Read data for the addressed register.

  // A command counts only when its device address matches.
  assign cmd_take = cmd_valid_i && (cmd_i.dev == `RMLC_DEV_ADDR);
  assign cmd_wr = cmd_take && cmd_i.write;

  // Any key other than the unlock value locks the map.
  assign map_locked = (write_protect_key != `RMLC_UNLOCK_KEY);

  // The key register is always writable; trim and variant only when unlocked.
  assign key_wr = cmd_wr && (cmd_i.reg_addr == `RMLC_ADDR_KEY);
  assign wr_allow = cmd_wr && (!map_locked || key_wr);

  // Trim word storage; written only when the write is allowed.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_word_b <= `RMLC_RST_TRIM_B;
    end else if (wr_allow && cmd_i.reg_addr == `RMLC_ADDR_TRIM_B) begin
      trim_word_b <= cmd_i.wdata;
    end
  end

  // Trim byte storage with its fixed reset value.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_byte_c <= `RMLC_RST_TRIM_C;
    end else if (wr_allow && cmd_i.reg_addr == `RMLC_ADDR_TRIM_C) begin
      trim_byte_c <= cmd_i.wdata[7:0];
    end
  end

  // Key storage; resets to the unlock value so the map starts open.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_protect_key <= `RMLC_RST_KEY;
    end else if (key_wr) begin
      write_protect_key <= cmd_i.wdata[7:0];
    end
  end

  // Variant word storage, starting from the product default.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      product_variant_word <= PRODUCT_VARIANT;
    end else if (wr_allow && cmd_i.reg_addr == `RMLC_ADDR_VARIANT) begin
      product_variant_word <= cmd_i.wdata[15:0];
    end
  end

  // Picks the configuration byte the engine folds in this step.
  always_comb begin
    case (byte_idx)
      3'h0: crc_byte = trim_word_b[23:16];
      3'h1: crc_byte = trim_word_b[15:8];
      3'h2: crc_byte = trim_word_b[7:0];
      3'h3: crc_byte = trim_byte_c;
      3'h4: crc_byte = write_protect_key;
      3'h5: crc_byte = product_variant_word[15:8];
      3'h6: crc_byte = product_variant_word[7:0];
      default: crc_byte = 8'h00;
    endcase
  end

  // One byte of checksum per enabled cycle.
  rmlc_crc_step u_crc_step (
    .crc_i(crc_acc),
    .data_i(crc_byte),
    .crc_o(next_crc)
  );

  // Checksum engine. It idles and shows zero while unlocked, and
  // restarts whenever the key is written, so a round never mixes
  // two key values. Steps happen only on master clock enables.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_state <= rmlc_pkg::RMLC_CRC_IDLE;
      byte_idx <= 3'h0;
      crc_acc <= `RMLC_CRC_INIT;
      config_checksum_value <= `RMLC_RST_CHECKSUM;
    end else if (!map_locked || key_wr) begin
      crc_state <= rmlc_pkg::RMLC_CRC_IDLE;
      byte_idx <= 3'h0;
      crc_acc <= `RMLC_CRC_INIT;
      // Unlocking, now or by this very write, clears the value.
      if (!map_locked || cmd_i.wdata[7:0] == `RMLC_UNLOCK_KEY) begin
        config_checksum_value <= 16'h0000;
      end
    end else if (digital_master_clock_i) begin
      case (crc_state)
        rmlc_pkg::RMLC_CRC_IDLE: begin
          // First enable after locking starts a round.
          crc_state <= rmlc_pkg::RMLC_CRC_RUN;
          byte_idx <= 3'h0;
          crc_acc <= `RMLC_CRC_INIT;
        end
        rmlc_pkg::RMLC_CRC_RUN: begin
          if (byte_idx == `RMLC_CRC_LAST_IDX) begin
            // Round done: publish and start over at once.
            config_checksum_value <= next_crc;
            crc_acc <= `RMLC_CRC_INIT;
            byte_idx <= 3'h0;
          end else begin
            crc_acc <= next_crc;
            byte_idx <= byte_idx + 3'h1;
          end
        end
        default: begin
          // Illegal code recovers to idle.
          crc_state <= rmlc_pkg::RMLC_CRC_IDLE;
          byte_idx <= 3'h0;
          crc_acc <= `RMLC_CRC_INIT;
        end
      endcase
    end
  end

  // Read multiplexer; lower and unknown addresses read as zero.
  always_comb begin
    case (cmd_i.reg_addr)
      `RMLC_ADDR_TRIM_B: next_rd_data = trim_word_b;
      `RMLC_ADDR_TRIM_C: next_rd_data = {16'h0000, trim_byte_c};
      `RMLC_ADDR_KEY: next_rd_data = {16'h0000, write_protect_key};
      `RMLC_ADDR_VARIANT: next_rd_data = {8'h00, product_variant_word};
      `RMLC_ADDR_CHECKSUM: next_rd_data = {8'h00, config_checksum_value};
      default: next_rd_data = 24'h000000;
    endcase
  end

  // Read answer, one cycle after a matching read command.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 24'h000000;
    end else begin
      rd_valid_o <= cmd_take && !cmd_i.write;
      if (cmd_take && !cmd_i.write) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  // Status flags. A blocked write is only reported; the front end
  // carries on with the rest of the transaction.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_o <= 1'b0;
      wr_blocked_o <= 1'b0;
      crc_valid_o <= 1'b0;
    end else begin
      locked_o <= map_locked;
      wr_blocked_o <= cmd_wr && !wr_allow;
      if (!map_locked || key_wr) begin
        crc_valid_o <= 1'b0;
      end else if (digital_master_clock_i &&
                   crc_state == rmlc_pkg::RMLC_CRC_RUN &&
                   byte_idx == `RMLC_CRC_LAST_IDX) begin
        crc_valid_o <= 1'b1;
      end
    end
  end

  // While unlocked the checksum always reads as zero.
  unlocked_crc_zero_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !map_locked |-> config_checksum_value == 16'h0000
  ) else $error("checksum nonzero while unlocked");

  // An unlocked write to the trim word lands.
  open_write_lands_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_wr && !map_locked && cmd_i.reg_addr == `RMLC_ADDR_TRIM_B
    |=> trim_word_b == $past(cmd_i.wdata)
  ) else $error("unlocked write to trim word lost");

  // A locked write to a protected register changes nothing.
  locked_write_held_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_wr && map_locked && cmd_i.reg_addr != `RMLC_ADDR_KEY
    |=> $stable(trim_word_b) && $stable(trim_byte_c) &&
        $stable(product_variant_word) && wr_blocked_o
  ) else $error("locked write altered a register");

  // The key stays writable while locked.
  key_writable_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    key_wr |=> write_protect_key == $past(cmd_i.wdata[7:0]) &&
               !wr_blocked_o
  ) else $error("key write refused");

  // A foreign device address draws no answer.
  foreign_addr_ignored_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_valid_i && cmd_i.dev != `RMLC_DEV_ADDR
    |=> !rd_valid_o && !wr_blocked_o
  ) else $error("answered a foreign device address");

  // A matching read answers on the next cycle.
  read_answer_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_take && !cmd_i.write |=> rd_valid_o
  ) else $error("read not answered");

  // The read strobe rises only after a matching read.
  read_pulse_only_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(cmd_take && !cmd_i.write) |=> !rd_valid_o
  ) else $error("read strobe without a read");

  // Without master clock enables the checksum holds while locked.
  crc_needs_clock_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    map_locked && !key_wr && !digital_master_clock_i
    |=> $stable(config_checksum_value) && $stable(byte_idx)
  ) else $error("checksum moved without master clock");

  // A checksum read returns the stored value.
  checksum_read_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_take && !cmd_i.write && cmd_i.reg_addr == `RMLC_ADDR_CHECKSUM
    |=> rd_data_o == {8'h00, $past(config_checksum_value)}
  ) else $error("checksum read mismatch");

  // With a running clock and steady lock a round ends in eight steps.
  crc_round_bound_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (map_locked && !key_wr && digital_master_clock_i) [*8]
    |=> crc_valid_o
  ) else $error("checksum round did not finish");

  // An unlocked write to the variant word lands.
  variant_write_lands_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_wr && !map_locked && cmd_i.reg_addr == `RMLC_ADDR_VARIANT
    |=> product_variant_word == $past(cmd_i.wdata[15:0])
  ) else $error("unlocked write to variant word lost");

  // A foreign device address changes no register.
  foreign_write_held_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    cmd_valid_i && cmd_i.dev != `RMLC_DEV_ADDR
    |=> $stable(trim_word_b) && $stable(trim_byte_c) &&
        $stable(write_protect_key) && $stable(product_variant_word)
  ) else $error("foreign command altered a register");

  // While unlocked no checksum round is reported as done.
  unlock_clears_valid_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !map_locked |=> !crc_valid_o
  ) else $error("checksum valid while unlocked");

  // The refusal flag follows only a matching write.
  blocked_flag_pulse_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !cmd_wr |=> !wr_blocked_o
  ) else $error("refusal flag without a write");

endmodule

// file: verification/register_map_lock_and_crc_tb.sv
// Self-checking bench for the upper register map with lock and checksum.
`timescale 1ns/1ps
`include "rmlc_consts.svh"

module register_map_lock_and_crc_tb;
  logic mclk_i = 1'b0; // Clock, 5 ns period.
  logic rst_n_i = 1'b0; // Reset, active low.
  logic master_run = 1'b0; // Master clock running enable.
  logic cmd_valid; // Command strobe from the host model.
  rmlc_pkg::rmlc_cmd_s cmd; // Command fields from the host model.
  logic rd_valid, locked, wr_blocked, crc_valid; // Status outputs.
  logic [23:0] rd_data; // Read answer.
  int mismatches = 0; // Failed comparisons.
  int samples_checked = 0; // All comparisons.
  logic v, b; // Seen read strobe and refusal pulse.
  logic [23:0] d; // Seen read data.

  // Clock generator.
  always #2.5 mclk_i = ~mclk_i;

  rmlc_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .digital_master_clock_i(master_run), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .locked_o(locked), .wr_blocked_o(wr_blocked), .crc_valid_o(crc_valid));

  rmlc_host_model host_u (.mclk_i(mclk_i), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .wr_blocked_i(wr_blocked),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd));

  // Compares one value and counts the result.
  task automatic check(input string name, input logic [23:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reads a register and expects an answer with the given value.
  task automatic rd(input logic [3:0] adr, input logic [23:0] exp,
      input string name);
    host_u.xfer(`RMLC_DEV_ADDR, adr, 1'b0, 24'h000000, v, d, b);
    check({name, " strobe"}, {23'h0, v}, 24'h000001);
    check(name, d, exp);
  endtask

  // Writes a register and checks whether the lock refused it.
  task automatic wr(input logic [3:0] adr, input logic [23:0] dat,
      input logic exp_b);
    host_u.xfer(`RMLC_DEV_ADDR, adr, 1'b1, dat, v, d, b);
    check("write refused", {23'h0, b}, {23'h0, exp_b});
  endtask

  // Checksum model: bytes MSB first, shift left, feedback on top bit.
  function automatic logic [15:0] crc_of(input logic [55:0] bytes);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 55; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ bytes[i]) ? `RMLC_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Reset values of the whole upper map.
  task automatic t_reset();
    rd(`RMLC_ADDR_TRIM_B, 24'h900000, "trim word");
    rd(`RMLC_ADDR_TRIM_C, 24'h000030, "trim byte");
    rd(`RMLC_ADDR_KEY, 24'h0000A5, "key");
    rd(`RMLC_ADDR_VARIANT, 24'h000000, "variant");
    rd(`RMLC_ADDR_CHECKSUM, 24'h000000, "checksum");
    check("locked", {23'h0, locked}, 24'h000000);
  endtask

  // Unlocked map takes writes and computes no checksum.
  task automatic t_unlocked();
    master_run = 1'b1;
    wr(`RMLC_ADDR_TRIM_B, 24'h123456, 1'b0);
    rd(`RMLC_ADDR_TRIM_B, 24'h123456, "trim word");
    wr(`RMLC_ADDR_TRIM_B, 24'h900000, 1'b0);
    wr(`RMLC_ADDR_VARIANT, 24'h00BEEF, 1'b0);
    rd(`RMLC_ADDR_VARIANT, 24'h00BEEF, "variant");
    wr(`RMLC_ADDR_VARIANT, 24'h000000, 1'b0);
    wr(`RMLC_ADDR_TRIM_C, 24'h000030, 1'b0);
    repeat (20) @(negedge mclk_i);
    rd(`RMLC_ADDR_CHECKSUM, 24'h000000, "checksum");
    check("crc valid", {23'h0, crc_valid}, 24'h000000);
    master_run = 1'b0;
  endtask

  // Commands with a foreign device address draw no answer, change nothing.
  task automatic t_devaddr();
    for (int i = 0; i < 4; i++) begin
      if (i[1:0] != `RMLC_DEV_ADDR) begin
        host_u.xfer(i[1:0], `RMLC_ADDR_TRIM_B, 1'b1, 24'h111111, v, d, b);
        check("foreign write", {22'h0, v, b}, 24'h000000);
        host_u.xfer(i[1:0], `RMLC_ADDR_TRIM_B, 1'b0, 24'h000000, v, d, b);
        check("foreign read", {23'h0, v}, 24'h000000);
      end
    end
    rd(`RMLC_ADDR_TRIM_B, 24'h900000, "trim word");
  endtask

  // Locking refuses writes; checksum runs only with the master clock.
  task automatic t_lock();
    wr(`RMLC_ADDR_KEY, 24'h000000, 1'b0);
    @(negedge mclk_i);
    check("locked", {23'h0, locked}, 24'h000001);
    wr(`RMLC_ADDR_TRIM_C, 24'h000055, 1'b1);
    wr(`RMLC_ADDR_TRIM_B, 24'h000001, 1'b1);
    wr(`RMLC_ADDR_VARIANT, 24'h000001, 1'b1);
    wr(`RMLC_ADDR_CHECKSUM, 24'h001234, 1'b1);
    rd(`RMLC_ADDR_TRIM_C, 24'h000030, "trim byte");
    rd(`RMLC_ADDR_KEY, 24'h000000, "key");
    repeat (10) @(negedge mclk_i);
    check("crc valid", {23'h0, crc_valid}, 24'h000000);
    rd(`RMLC_ADDR_CHECKSUM, 24'h000000, "checksum");
    master_run = 1'b1;
    wait_crc();
    rd(`RMLC_ADDR_CHECKSUM, {8'h00, crc_of({24'h900000, 8'h30, 8'h00,
      16'h0000})}, "checksum");
    // A new locking key restarts the round and enters the sum.
    wr(`RMLC_ADDR_KEY, 24'h00005A, 1'b0);
    check("crc valid", {23'h0, crc_valid}, 24'h000000);
    wait_crc();
    rd(`RMLC_ADDR_CHECKSUM, {8'h00, crc_of({24'h900000, 8'h30, 8'h5A,
      16'h0000})}, "checksum");
  endtask

  // Key stays writable; unlocking clears the checksum.
  task automatic t_unlock();
    wr(`RMLC_ADDR_KEY, 24'h0000A5, 1'b0);
    check("crc valid", {23'h0, crc_valid}, 24'h000000);
    rd(`RMLC_ADDR_CHECKSUM, 24'h000000, "checksum");
    wr(`RMLC_ADDR_TRIM_C, 24'h000030, 1'b0);
    master_run = 1'b0;
  endtask

  // Waits for a finished checksum round; a timeout ends the run.
  task automatic wait_crc();
    for (int i = 0; i < 20 && crc_valid !== 1'b1; i++) begin
      @(negedge mclk_i);
    end
    if (crc_valid !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // A reset in mid-run reopens the map and clears the checksum.
  task automatic t_midreset();
    wr(`RMLC_ADDR_KEY, 24'h00003C, 1'b0);
    master_run = 1'b1;
    wait_crc();
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check("crc valid", {23'h0, crc_valid}, 24'h000000);
    rd(`RMLC_ADDR_KEY, 24'h0000A5, "key");
    rd(`RMLC_ADDR_CHECKSUM, 24'h000000, "checksum");
    check("locked", {23'h0, locked}, 24'h000000);
    master_run = 1'b0;
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_unlocked();
    t_devaddr();
    t_lock();
    t_unlock();
    t_midreset();
    report_and_stop();
  end
endmodule

// file: verification/rmlc_host_model.sv
// Host model that issues register commands to the block.
`timescale 1ns/1ps

module rmlc_host_model (
  // Clock.
  input wire logic mclk_i,
  // Answers from the block.
  input wire logic rd_valid_i,
  input wire logic [23:0] rd_data_i,
  input wire logic wr_blocked_i,
  // Command towards the block.
  output logic cmd_valid_o,
  output rmlc_pkg::rmlc_cmd_s cmd_o
);
  // Idle until the first command is issued.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end

  // One command: raised after a falling edge, taken at the next rising
  // edge, answer sampled at the falling edge that follows.
  task automatic xfer(input logic [1:0] dev, input logic [3:0] adr,
      input logic wr, input logic [23:0] dat, output logic seen_v,
      output logic [23:0] seen_d, output logic seen_b);
    @(negedge mclk_i);
    cmd_o = '{dev: dev, reg_addr: adr, write: wr, wdata: dat};
    cmd_valid_o = 1'b1;
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    // Fields no longer qualified are scrambled, not left standing.
    cmd_o = ~cmd_o;
    seen_v = rd_valid_i;
    seen_d = rd_data_i;
    seen_b = wr_blocked_i;
  endtask
endmodule
